/* safety_cfg.svh */
// Constants shared by both ends of the safe-stop supervision link.
// Assumes a single 100 MHz clock on both ends.
`ifndef SAFETY_CFG_SVH
`define SAFETY_CFG_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_PERIOD_NS 10

// ----------------------------------------
// Times in their own units
// ----------------------------------------
`define DISC_LIMIT_MS 50
`define RELAY_DROP_MS 15
`define CON_DELAY_US 250
`define SD_REACT_US 130
`define FB_PERIOD_MS 1
`define FC_DECIDE_MS 1
`define OUT_DELAY_US 200

// ----------------------------------------
// Times as clock cycles
// ----------------------------------------
`define DISC_LIMIT_CYC (`DISC_LIMIT_MS * 1000000 / `CLK_PERIOD_NS)
`define RELAY_DROP_CYC (`RELAY_DROP_MS * 1000000 / `CLK_PERIOD_NS)
`define CON_DELAY_CYC (`CON_DELAY_US * 1000 / `CLK_PERIOD_NS)
`define SD_REACT_CYC (`SD_REACT_US * 1000 / `CLK_PERIOD_NS)
`define FB_PERIOD_CYC (`FB_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define FC_DECIDE_CYC (`FC_DECIDE_MS * 1000000 / `CLK_PERIOD_NS)
`define OUT_DELAY_CYC (`OUT_DELAY_US * 1000 / `CLK_PERIOD_NS)

// Braking window of a controlled stop, kept inside the relay drop-out time
`define BRAKE_DEFAULT_CYC (`RELAY_DROP_CYC * 2 / 3)
// Length of one release-test step, well below the discrepancy limit
`define TEST_STEP_DEFAULT_CYC (`DISC_LIMIT_CYC * 2 / 5)

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define CNT_W 24
`define STOP_CAT_0 1'b0
`define STOP_CAT_1 1'b1
`define RST_LOW 1'b0
`define RST_HIGH 1'b1

`endif

/* safety_pkg.sv */
// Types shared by both ends of the safe-stop supervision link.
// Assumes safety_cfg.svh is on the include path.
`include "safety_cfg.svh"

package safety_pkg;

  // ----------------------------------------
  // Drive-side states
  // ----------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,  // Controller off, relays follow commands
    S_RUN = 2'h1,   // Controller enabled
    S_BRAKE = 2'h2, // Controlled stop in progress
    S_STOP = 2'h3   // Energy removed, waits for release
  } dev_state_t;

  // ----------------------------------------
  // Controller-side states
  // ----------------------------------------
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,  // Waiting for test start
    H_STEP1 = 3'h1, // Both relays off
    H_STEP2 = 3'h2, // Relay A alone
    H_STEP3 = 3'h3, // Relay B alone
    H_RUN = 3'h4,   // Commissioned, monitoring
    H_FAIL = 3'h5   // Safety function defective
  } host_state_t;

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  typedef struct packed {
    dev_state_t st;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [`CNT_W-1:0] disc_cnt;
    logic [`CNT_W-1:0] brake_cnt;
    logic en_prev;
    logic fault_disc;
    logic fault_norelay;
    logic relay_a;
    logic relay_b;
    logic inh_up;
    logic inh_lo;
    logic ctrl_en;
    logic brake;
  } dev_regs_t;

  typedef struct packed {
    host_state_t st;
    logic [1:0] sync_mv;
    logic [`CNT_W-1:0] cnt;
    logic [`CNT_W-1:0] mis_cnt;
    logic cmd_a;
    logic cmd_b;
    logic enable;
    logic stop;
    logic stop_cat;
    logic clr;
    logic contactor;
    logic pass;
    logic fail;
  } host_regs_t;

endpackage

/* safety_link_if.sv */
// Link between the drive's supervision logic and the fieldbus controller.
// Both ends share one clock; the bench joins them through this interface.
interface safety_link_if;

  // ----------------------------------------
  // Controller to drive
  // ----------------------------------------
  logic relay_a_cmd;   // Energise safety relay A
  logic relay_b_cmd;   // Energise safety relay B
  logic enable_req;    // Drive enable, rising edge starts
  logic stop_req;      // Stop request, level
  logic stop_cat;      // Stop category, 0 or 1
  logic fault_clear;   // Clears latched faults, pulse

  // ----------------------------------------
  // Drive to controller
  // ----------------------------------------
  logic relay_a_state; // Synchronised contact A
  logic relay_b_state; // Synchronised contact B
  logic fault_disc;    // Contact discrepancy fault
  logic fault_norelay; // Enabled without relays fault
  logic drive_active;  // Controller enabled

  modport drive (
    input relay_a_cmd, relay_b_cmd, enable_req, stop_req, stop_cat, fault_clear,
    output relay_a_state, relay_b_state, fault_disc, fault_norelay, drive_active
  );

  modport ctrl (
    output relay_a_cmd, relay_b_cmd, enable_req, stop_req, stop_cat, fault_clear,
    input relay_a_state, relay_b_state, fault_disc, fault_norelay, drive_active
  );

endinterface

/* safe_stop_drive.sv */
// Safe-stop supervision logic of the servo drive.
// Assumes the controller end on the same clock, contacts arriving from pins.
`include "safety_cfg.svh"

module safe_stop_drive
  import safety_pkg::*;
#(
  parameter int DISC_CYC = `DISC_LIMIT_CYC,  // Contact discrepancy limit
  parameter int BRAKE_CYC = `BRAKE_DEFAULT_CYC // Category 1 braking window
) (
  input wire logic clk,                 // 100 MHz clock
  input wire logic reset,               // Synchronous reset, high
  safety_link_if.drive link,            // Link to fieldbus controller
  input wire logic aux_contact_a,       // Relay A auxiliary contact pin
  input wire logic aux_contact_b,       // Relay B auxiliary contact pin
  output logic safety_relay_a,          // Relay A coil drive
  output logic safety_relay_b,          // Relay B coil drive
  output logic gate_inhibit_upper,      // Blocks upper power switches
  output logic gate_inhibit_lower,      // Blocks lower power switches
  output logic controller_enable,       // Motor controller enable
  output logic brake_active             // Controlled braking in progress
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  dev_regs_t r_reg; // Registered state
  dev_regs_t r_next; // Next state

  // ----------------------------------------
  // Fault check helpers
  // ----------------------------------------

  // Timer end reached for a given count and limit
  function automatic logic cnt_done(input logic [`CNT_W-1:0] cnt, input int lim);
    logic [`CNT_W-1:0] last;
    last = `CNT_W'(lim - 1);
    return cnt >= last;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  // Contact sampling, discrepancy timer, faults and stop sequencing
  always_comb begin
    logic a;
    logic b;
    logic fault_any;
    logic en_rise;
    a = 1'b0;
    b = 1'b0;
    fault_any = 1'b0;
    en_rise = 1'b0;
    r_next = r_reg;

    // Two-flop synchronisers, only the second stage is read
    r_next.sync_a = {r_reg.sync_a[0], aux_contact_a};
    r_next.sync_b = {r_reg.sync_b[0], aux_contact_b};
    a = r_reg.sync_a[1];
    b = r_reg.sync_b[1];

    // Clear first so that a fault in the same cycle wins
    if (link.fault_clear) begin
      r_next.fault_disc = 1'b0;
      r_next.fault_norelay = 1'b0;
    end

    // Discrepancy timer runs only while the contacts disagree
    if (a != b) begin
      if (cnt_done(r_reg.disc_cnt, DISC_CYC)) begin
        r_next.fault_disc = 1'b1;
      end else begin
        r_next.disc_cnt = r_reg.disc_cnt + `CNT_W'(1);
      end
    end else begin
      r_next.disc_cnt = '0;
    end

    // Controller enabled while either relay is dropped
    if (r_reg.ctrl_en && !(a && b)) begin
      r_next.fault_norelay = 1'b1;
    end

    fault_any = r_next.fault_disc || r_next.fault_norelay;
    en_rise = link.enable_req && !r_reg.en_prev;
    r_next.en_prev = link.enable_req;
    r_next.brake = 1'b0;

    case (r_reg.st)
      // Idle: relays follow commands, start only on a fresh enable edge
      S_IDLE: begin
        r_next.brake_cnt = '0;
        if (link.stop_req) begin
          r_next.st = S_STOP;
        end else if (en_rise && !fault_any) begin
          // A latched fault refuses the enable edge
          r_next.st = S_RUN;
        end
      end
      // Running: stop wins over everything else
      S_RUN: begin
        if (link.stop_req && link.stop_cat == `STOP_CAT_1) begin
          r_next.st = S_BRAKE;
          r_next.brake_cnt = '0;
        end else if (link.stop_req || fault_any) begin
          r_next.st = S_STOP;
        end else if (!link.enable_req) begin
          r_next.st = S_IDLE;
        end
      end
      // Controlled stop: keep energy for the braking window
      S_BRAKE: begin
        if (fault_any || link.stop_cat == `STOP_CAT_0) begin
          r_next.st = S_STOP;
        end else if (cnt_done(r_reg.brake_cnt, BRAKE_CYC)) begin
          r_next.st = S_STOP;
        end else begin
          r_next.brake_cnt = r_reg.brake_cnt + `CNT_W'(1);
        end
      end
      // Stopped: leave only when stop and enable are both gone
      S_STOP: begin
        if (!link.stop_req && !link.enable_req) begin
          r_next.st = S_IDLE;
        end
      end
      default: begin
        r_next.st = S_STOP;
      end
    endcase

    // Braking output while the controlled stop runs
    r_next.brake = (r_next.st == S_BRAKE);

    // Controller runs only in run and braking states
    r_next.ctrl_en = (r_next.st == S_RUN) || (r_next.st == S_BRAKE);

    // Relays dropped once stopped, otherwise as commanded
    if (r_next.st == S_STOP) begin
      r_next.relay_a = 1'b0;
      r_next.relay_b = 1'b0;
    end else begin
      r_next.relay_a = link.relay_a_cmd;
      r_next.relay_b = link.relay_b_cmd;
    end

    // Independent inhibit channels, one per bridge half
    r_next.inh_up = !(r_next.relay_a && r_next.ctrl_en);
    r_next.inh_lo = !(r_next.relay_b && r_next.ctrl_en);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------

  // Single register stage for the whole state
  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg.st <= S_IDLE;
      r_reg.sync_a <= 2'h0;
      r_reg.sync_b <= 2'h0;
      r_reg.disc_cnt <= '0;
      r_reg.brake_cnt <= '0;
      r_reg.en_prev <= `RST_HIGH;
      r_reg.fault_disc <= `RST_LOW;
      r_reg.fault_norelay <= `RST_LOW;
      r_reg.relay_a <= `RST_LOW;
      r_reg.relay_b <= `RST_LOW;
      r_reg.inh_up <= `RST_HIGH;
      r_reg.inh_lo <= `RST_HIGH;
      r_reg.ctrl_en <= `RST_LOW;
      r_reg.brake <= `RST_LOW;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------

  // Pin side
  assign safety_relay_a = r_reg.relay_a;
  assign safety_relay_b = r_reg.relay_b;
  assign gate_inhibit_upper = r_reg.inh_up;
  assign gate_inhibit_lower = r_reg.inh_lo;
  assign controller_enable = r_reg.ctrl_en;
  assign brake_active = r_reg.brake;

  // Status to controller, updated every cycle
  assign link.relay_a_state = r_reg.sync_a[1];
  assign link.relay_b_state = r_reg.sync_b[1];
  assign link.fault_disc = r_reg.fault_disc;
  assign link.fault_norelay = r_reg.fault_norelay;
  assign link.drive_active = r_reg.ctrl_en;

endmodule

/* safe_stop_ctrl.sv */
// Fieldbus controller end: release test and contactor supervision.
// Assumes the drive end on the same clock; motion feedback from a pin.
`include "safety_cfg.svh"

module safe_stop_ctrl
  import safety_pkg::*;
#(
  parameter int STEP_CYC = `TEST_STEP_DEFAULT_CYC, // One release-test step
  parameter int DECIDE_CYC = `FC_DECIDE_CYC        // Mismatch decision time
) (
  input wire logic clk,             // 100 MHz clock
  input wire logic reset,           // Synchronous reset, high
  safety_link_if.ctrl link,         // Link to drive
  input wire logic start_test,      // Start release test, pulse
  input wire logic motor_moved,     // Motion detected, pin
  input wire logic user_enable,     // Drive enable in service
  input wire logic user_stop,       // Stop request in service
  input wire logic user_stop_cat,   // Stop category in service
  output logic contactor_on,        // Main contactor closed
  output logic test_pass,           // Commissioning allowed
  output logic test_fail            // Safety function defective
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  host_regs_t h_reg; // Registered state
  host_regs_t h_next; // Next state

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  // Release test sequencing and in-service monitoring
  always_comb begin
    logic moved;
    logic half;
    logic mid;
    logic last;
    logic plaus;
    logic diag;
    h_next = h_reg;
    h_next.sync_mv = {h_reg.sync_mv[0], motor_moved};
    moved = h_reg.sync_mv[1];
    half = h_reg.cnt >= `CNT_W'(STEP_CYC / 2);
    // Last cycle before the enable: contacts settled, no fault yet
    mid = h_reg.cnt == `CNT_W'(STEP_CYC / 2 - 1);
    last = h_reg.cnt >= `CNT_W'(STEP_CYC - 1);
    plaus = (link.relay_a_state == h_reg.cmd_a) && (link.relay_b_state == h_reg.cmd_b);
    diag = link.fault_disc || link.fault_norelay;
    h_next.clr = 1'b0;
    h_next.cnt = h_reg.cnt + `CNT_W'(1);

    case (h_reg.st)
      // Waiting: contactor open until a test is started
      H_IDLE: begin
        h_next.cnt = '0;
        if (start_test) begin
          h_next.st = H_STEP1;
          h_next.contactor = 1'b1;
          h_next.cmd_a = 1'b0;
          h_next.cmd_b = 1'b0;
          h_next.clr = 1'b1;
        end
      end
      // Test steps: enable in second half, watch motion, check contacts
      H_STEP1, H_STEP2, H_STEP3: begin
        h_next.enable = half;
        if (half && moved) begin
          h_next.st = H_FAIL;
        end else if (mid && !plaus) begin
          // Checked before enabling: a step fault drops the relays later
          h_next.st = H_FAIL;
        end else if (last) begin
          h_next.cnt = '0;
          h_next.enable = 1'b0;
          h_next.clr = 1'b1;
          h_next.st = (h_reg.st == H_STEP1) ? H_STEP2 :
                      (h_reg.st == H_STEP2) ? H_STEP3 : H_RUN;
          h_next.cmd_a = (h_reg.st == H_STEP1);
          h_next.cmd_b = (h_reg.st == H_STEP2);
          h_next.pass = (h_reg.st == H_STEP3);
        end
      end
      // In service: relays on, user commands passed through
      H_RUN: begin
        h_next.cmd_a = 1'b1;
        h_next.cmd_b = 1'b1;
        h_next.enable = user_enable;
        h_next.stop = user_stop;
        h_next.stop_cat = user_stop_cat;
        h_next.mis_cnt = plaus ? '0 : h_reg.mis_cnt + `CNT_W'(1);
        // Faults left from the last test step are still in flight
        if (diag && !h_reg.clr) begin
          h_next.st = H_FAIL;
        end else if (h_reg.mis_cnt >= `CNT_W'(DECIDE_CYC - 1)) begin
          h_next.st = H_FAIL;
        end
      end
      // Defective: held until reset
      H_FAIL: begin
        h_next.cnt = '0;
      end
      default: begin
        h_next.st = H_FAIL;
      end
    endcase

    // Failure opens contactor and blocks commissioning
    if (h_next.st == H_FAIL) begin
      h_next.contactor = 1'b0;
      h_next.pass = 1'b0;
      h_next.fail = 1'b1;
      h_next.enable = 1'b0;
      h_next.stop = 1'b1;
      h_next.stop_cat = `STOP_CAT_0;
      h_next.cmd_a = 1'b0;
      h_next.cmd_b = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------

  // Single register stage for the whole state
  always_ff @(posedge clk) begin
    if (reset) begin
      h_reg.st <= H_IDLE;
      h_reg.sync_mv <= 2'h0;
      h_reg.cnt <= '0;
      h_reg.mis_cnt <= '0;
      h_reg.cmd_a <= `RST_LOW;
      h_reg.cmd_b <= `RST_LOW;
      h_reg.enable <= `RST_LOW;
      h_reg.stop <= `RST_LOW;
      h_reg.stop_cat <= `STOP_CAT_0;
      h_reg.clr <= `RST_LOW;
      h_reg.contactor <= `RST_LOW;
      h_reg.pass <= `RST_LOW;
      h_reg.fail <= `RST_LOW;
    end else begin
      h_reg <= h_next;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  assign link.relay_a_cmd = h_reg.cmd_a;
  assign link.relay_b_cmd = h_reg.cmd_b;
  assign link.enable_req = h_reg.enable;
  assign link.stop_req = h_reg.stop;
  assign link.stop_cat = h_reg.stop_cat;
  assign link.fault_clear = h_reg.clr;
  assign contactor_on = h_reg.contactor;
  assign test_pass = h_reg.pass;
  assign test_fail = h_reg.fail;

endmodule

/* safety_link_checker.sv */
// Concurrent checks on the link between drive end and controller end.
// Assumes the bench instantiates it beside the link interface.
module safety_link_checker #(
  parameter int DISC_CYC = 50, // Contact discrepancy limit
  parameter int BRAKE_CYC = 20 // Category 1 braking window
) (
  input wire logic clk, // Clock
  input wire logic reset, // Sync reset, high
  input wire logic stop_req, // Stop request
  input wire logic stop_cat, // Stop category
  input wire logic enable_req, // Enable request
  input wire logic fault_clear, // Fault clear pulse
  input wire logic relay_a_state, // Synced contact A
  input wire logic relay_b_state, // Synced contact B
  input wire logic fault_disc, // Discrepancy fault
  input wire logic fault_norelay, // No-relay fault
  input wire logic drive_active // Controller enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BRK_HI = BRAKE_CYC + 4; // Slack on the braking window

  // ----------------------------------------
  // Mismatch run length
  // ----------------------------------------
  logic [31:0] mis_reg; // Cycles the contacts have differed

  // Counts consecutive disagreement, cleared on agreement
  always_ff @(posedge clk) begin
    mis_reg <= (reset || relay_a_state == relay_b_state) ? 32'h0 : mis_reg + 32'h1;
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_stop_cat0;
    stop_req && !stop_cat |=> !drive_active;
  endproperty
  a_stop_cat0: assert property (p_stop_cat0) else $error("stop left drive on");

  property p_no_restart;
    $rose(drive_active) |-> $past(enable_req) && !$past(enable_req, 2);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("start without edge");

  property p_brake;
    $rose(stop_req) && stop_cat && drive_active |=> drive_active [*8] ##[1:BRK_HI] !drive_active;
  endproperty
  a_brake: assert property (p_brake) else $error("braking window wrong");

  property p_disc_min;
    $rose(fault_disc) |-> mis_reg >= DISC_CYC - 1;
  endproperty
  a_disc_min: assert property (p_disc_min) else $error("discrepancy fault early");

  property p_disc_max;
    mis_reg >= DISC_CYC + 3 |-> fault_disc;
  endproperty
  a_disc_max: assert property (p_disc_max) else $error("discrepancy fault late");

  property p_disc_stop;
    $rose(fault_disc) |-> ##[0:2] !drive_active;
  endproperty
  a_disc_stop: assert property (p_disc_stop) else $error("fault left drive on");

  property p_norelay;
    drive_active && !(relay_a_state && relay_b_state) |-> ##[1:2] fault_norelay;
  endproperty
  a_norelay: assert property (p_norelay) else $error("no-relay fault missing");

  property p_latch;
    fault_disc && !fault_clear |=> fault_disc;
  endproperty
  a_latch: assert property (p_latch) else $error("fault not held");
endmodule

/* test_safety_relay_discrepancy_monitor.sv */
// Bench joining drive end and controller end over the link.
// Assumes design files and checker are compiled first.
module test_safety_relay_discrepancy_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DISC = 50; // Short discrepancy limit
  localparam int BRK = 20; // Short braking window
  localparam int STEP = 20; // Two steps stay below DISC
  localparam int DECIDE = 80; // Above DISC so drive faults first
  logic clk; // Clock
  logic reset; // Sync reset
  logic flip_a; // Inverts contact A
  logic flip_b; // Inverts contact B
  logic start_test; // Release test start
  logic motor_moved; // Motion pin
  logic user_enable; // Service enable
  logic user_stop; // Service stop
  logic user_stop_cat; // Service stop category
  logic relay_a; // Coil A
  logic relay_b; // Coil B
  logic inh_up; // Upper inhibit
  logic inh_lo; // Lower inhibit
  logic ctl_en; // Controller enable
  logic brk; // Braking
  logic con_on; // Contactor
  logic t_pass; // Test passed
  logic t_fail; // Test failed
  int mismatches; // Mismatch count
  int check_count; // Comparison count
  int k; // Loop index

  // ----------------------------------------
  // Ends and checker
  // ----------------------------------------
  safety_link_if lk ();
  // Contacts follow coils unless flipped
  safe_stop_drive #(.DISC_CYC(DISC), .BRAKE_CYC(BRK)) u_safe_stop_drive (
    .clk(clk), .reset(reset), .link(lk.drive),
    .aux_contact_a(relay_a ^ flip_a), .aux_contact_b(relay_b ^ flip_b),
    .safety_relay_a(relay_a), .safety_relay_b(relay_b),
    .gate_inhibit_upper(inh_up), .gate_inhibit_lower(inh_lo),
    .controller_enable(ctl_en), .brake_active(brk));
  safe_stop_ctrl #(.STEP_CYC(STEP), .DECIDE_CYC(DECIDE)) u_safe_stop_ctrl (
    .clk(clk), .reset(reset), .link(lk.ctrl), .start_test(start_test),
    .motor_moved(motor_moved), .user_enable(user_enable), .user_stop(user_stop),
    .user_stop_cat(user_stop_cat), .contactor_on(con_on), .test_pass(t_pass),
    .test_fail(t_fail));
  safety_link_checker #(.DISC_CYC(DISC), .BRAKE_CYC(BRK)) u_safety_link_checker (
    .clk(clk), .reset(reset), .stop_req(lk.stop_req), .stop_cat(lk.stop_cat),
    .enable_req(lk.enable_req), .fault_clear(lk.fault_clear),
    .relay_a_state(lk.relay_a_state), .relay_b_state(lk.relay_b_state),
    .fault_disc(lk.fault_disc), .fault_norelay(lk.fault_norelay),
    .drive_active(lk.drive_active));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compare and count
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Wait falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Reset both ends, run release test until verdict
  task automatic bring_up(input logic mv, input logic fl);
    int i;
    @(negedge clk);
    reset = 1'b1;
    user_enable = 1'b0;
    user_stop = 1'b0;
    user_stop_cat = 1'b0;
    motor_moved = mv;
    flip_a = 1'b0;
    flip_b = 1'b0;
    cyc(3);
    reset = 1'b0;
    start_test = 1'b1;
    flip_a = fl;
    cyc(1);
    start_test = 1'b0;
    for (i = 0; i < 300 && t_pass !== 1'b1 && t_fail !== 1'b1; i++) cyc(1);
    // Lets relays and synced contacts settle before service commands
    cyc(5);
  endtask

  // Verdict and end of run
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short
  initial begin
    #50000;
    mismatches++;
    final_report();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    flip_a = 1'b0;
    flip_b = 1'b0;
    start_test = 1'b0;
    motor_moved = 1'b0;
    user_enable = 1'b0;
    user_stop = 1'b0;
    user_stop_cat = 1'b0;
    mismatches = 0;
    check_count = 0;
    // Sound relays pass the release test
    bring_up(1'b0, 1'b0);
    chk(8'h1, t_pass);
    chk(8'h0, t_fail);
    chk(8'h1, con_on);
    // Motion, then implausible contact, block commissioning
    for (k = 0; k < 2; k++) begin
      bring_up(k == 0, k == 1);
      chk(8'h0, t_pass);
      chk(8'h1, t_fail);
      chk(8'h0, con_on);
    end
    // Category 0 stop, release without new enable
    bring_up(1'b0, 1'b0);
    user_enable = 1'b1;
    cyc(3);
    chk(8'h1, ctl_en);
    chk(8'h0, {inh_up, inh_lo});
    user_stop = 1'b1;
    cyc(3);
    chk(8'h0, ctl_en);
    chk(8'h3, {inh_up, inh_lo});
    chk(8'h0, {relay_a, relay_b});
    user_stop = 1'b0;
    cyc(10);
    chk(8'h0, ctl_en);
    cyc(DECIDE + 20);
    chk(8'h1, t_fail);
    chk(8'h0, con_on);
    // Category 1 stop brakes, then cuts
    bring_up(1'b0, 1'b0);
    user_enable = 1'b1;
    user_stop_cat = 1'b1;
    cyc(3);
    user_stop = 1'b1;
    cyc(8);
    chk(8'h1, ctl_en);
    chk(8'h1, brk);
    cyc(BRK);
    chk(8'h0, ctl_en);
    chk(8'h0, brk);
    chk(8'h0, {relay_a, relay_b});
    // Discrepancy with drive idle: a short run, then a long one
    bring_up(1'b0, 1'b0);
    flip_b = 1'b1;
    cyc(30);
    flip_b = 1'b0;
    cyc(5);
    chk(8'h0, lk.fault_disc);
    flip_b = 1'b1;
    cyc(30);
    chk(8'h0, lk.fault_disc);
    cyc(30);
    chk(8'h1, lk.fault_disc);
    flip_b = 1'b0;
    user_enable = 1'b1;
    cyc(5);
    chk(8'h1, lk.fault_disc);
    chk(8'h0, ctl_en);
    chk(8'h0, con_on);
    final_report();
  end
endmodule
